// >>> gpx_defines.svh
// Purpose: constants of the four-pin port with serial pin sharing
// Assumes: register index times four is the APB byte address
// Notes:   reset values and field positions live here, types in gpx_pkg
//
// Behaviour
// - four pins, each input or output
// - reset sets all four output latch bits
// - reset clears direction and function registers
// - pin three: port or slave/master serial clock
// - pin two: port or master/slave MISO
// - pin one: port input feeds slave MOSI
// - pin zero doubles as active-low slave select
// - serial inputs always forwarded from pins
`ifndef GPX_DEFINES_SVH
`define GPX_DEFINES_SVH

`define GPX_NPINS        4
`define GPX_ODE_W        3
`define GPX_IDX_DATA     8'h12
`define GPX_IDX_DIR      8'h14
`define GPX_IDX_FUNC     8'h15
`define GPX_IDX_ODE      8'h16
`define GPX_IDX_STAT     8'h17
`define GPX_RST_LATCH    4'hF
`define GPX_RST_DIR      4'h0
`define GPX_RST_FUNC     4'h0
`define GPX_RST_ODE      3'h0
`define GPX_RST_SYNC     4'hF
`define GPX_STAT_LVL_LSB 0
`define GPX_STAT_DRV_LSB 4
`define GPX_STAT_FN_LSB  8
`define GPX_STAT_MFD_BIT 12
`define GPX_STAT_BAD_BIT 13
`define GPX_PIN_SS       0
`define GPX_PIN_MOSI     1
`define GPX_PIN_MISO     2
`define GPX_PIN_SCLK     3

`endif

// >>> gpx_pkg.sv
// Purpose: types shared by the port top and its pin cells
// Assumes: gpx_defines.svh supplies widths
// Notes:   pin mode decode is shared, so it is a function here
`include "gpx_defines.svh"
package gpx_pkg;

  typedef enum logic [1:0] {
    GPX_PIN_IN,
    GPX_PIN_OUT,
    GPX_PIN_FUNC,
    GPX_PIN_BAD
  } gpx_pin_mode_t;

  typedef struct packed {
    logic [`GPX_NPINS-1:0] latch;
    logic [`GPX_NPINS-1:0] dir;
    logic [`GPX_NPINS-1:0] fn;
    logic [`GPX_ODE_W-1:0] open_drain_enable;
    logic [31:0]           rdata;
    logic                  slverr;
  } gpx_regs_t;

  typedef struct packed {
    logic o;
    logic oe;
  } gpx_cell_t;

  function automatic gpx_pin_mode_t gpx_pin_mode(input logic dir, input logic fn);
    gpx_pin_mode_t m;
    m = GPX_PIN_BAD;
    case ({dir, fn})
      2'b00:   m = GPX_PIN_IN;
      2'b10:   m = GPX_PIN_OUT;
      2'b11:   m = GPX_PIN_FUNC;
      default: m = GPX_PIN_BAD;
    endcase
    return m;
  endfunction : gpx_pin_mode

endpackage : gpx_pkg

// >>> gpx_sync.sv
// Purpose: two-flop synchroniser for the pin inputs
// Assumes: inputs are asynchronous to pclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module gpx_sync #(
  parameter int unsigned          W       = 4,
  parameter logic [W-1:0]         RST_VAL = '1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } gpx_sync_t;

  gpx_sync_t s_q;
  gpx_sync_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.meta   = d;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= {RST_VAL, RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stable;
endmodule : gpx_sync

// >>> gpx_pin_cell.sv
// Purpose: output side of one shared pin
// Assumes: mode already decoded from direction and function bits
// Notes:   outputs are registered, so a pin follows its source one cycle late
`timescale 1ns/1ps
module gpx_pin_cell (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  gpx_pkg::gpx_pin_mode_t     mode,
  input  wire logic                  latch,
  input  wire logic                  func_out,
  input  wire logic                  od_en,
  output logic                       pin_o,
  output logic                       pin_oe
);
  gpx_pkg::gpx_cell_t c_q;
  gpx_pkg::gpx_cell_t c_d;
  logic               val;
  logic               drive;

  always_comb begin
    c_d   = '0;
    val   = 1'b0;
    drive = 1'b0;
    case (mode)
      gpx_pkg::GPX_PIN_OUT: begin
        val   = latch;
        drive = 1'b1;
      end
      gpx_pkg::GPX_PIN_FUNC: begin
        val   = func_out;
        drive = 1'b1;
      end
      // forbidden function-without-direction stays undriven
      default: begin
        val   = 1'b0;
        drive = 1'b0;
      end
    endcase
    if (drive && od_en) begin
      c_d.o  = 1'b0;
      c_d.oe = ~val;
    end else begin
      c_d.o  = val;
      c_d.oe = drive;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign pin_o  = c_q.o;
  assign pin_oe = c_q.oe;
endmodule : gpx_pin_cell

// >>> gpx_port.sv
// Purpose: four-pin general-purpose port whose pins also carry serial signals
// Assumes: APB3/APB4 slave, zero wait states, registers in byte lane 0, status in lanes 0 and 1
// Notes:   serial shifter sits outside; this block only routes its pins
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "gpx_defines.svh"
module gpx_port #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [3:0]        pin_i,
  output logic      [3:0]        pin_o,
  output logic      [3:0]        pin_oe,
  output logic                   sei_ss_n,
  output logic                   sei_mosi_in,
  output logic                   sei_miso_in,
  output logic                   sei_sclk_in,
  input  wire logic              sei_mosi_out,
  input  wire logic              sei_miso_out,
  input  wire logic              sei_sclk_out,
  output logic                   sei_mode_fault_disable,
  output logic                   sei_sclk_master
);
  localparam int unsigned NP = `GPX_NPINS;

  gpx_pkg::gpx_regs_t     r_q;
  gpx_pkg::gpx_regs_t     r_d;
  gpx_pkg::gpx_pin_mode_t mode     [NP];
  logic [NP-1:0]          pin_sync;
  logic [NP-1:0]          func_out;
  logic [NP-1:0]          od_en;
  logic [NP-1:0]          drv_map;
  logic [NP-1:0]          fn_map;
  logic [NP-1:0]          data_view;
  logic                   bad_cfg;
  logic                   setup;
  logic                   access;

  // word hit: high bits zero, index in bits 9:2, byte offset zero
  function automatic logic gpx_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    logic ok;
    ok = (a[1:0] == 2'h0) && (a[9:2] == idx);
    if (ADDR_W > 10) begin
      ok = ok && (a >> 10) == '0;
    end
    return ok;
  endfunction : gpx_hit

  function automatic logic gpx_mapped(input logic [ADDR_W-1:0] a);
    return gpx_hit(a, `GPX_IDX_DATA) || gpx_hit(a, `GPX_IDX_DIR) ||
           gpx_hit(a, `GPX_IDX_FUNC) || gpx_hit(a, `GPX_IDX_ODE) ||
           gpx_hit(a, `GPX_IDX_STAT);
  endfunction : gpx_mapped

  // pin levels after two flops; ss_n idles inactive through reset
  gpx_sync #(
    .W       (NP),
    .RST_VAL (`GPX_RST_SYNC)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pin_i),
    .q       (pin_sync)
  );

  // serial inputs have no switch: always forwarded, even in port use
  assign sei_ss_n    = pin_sync[`GPX_PIN_SS];
  assign sei_mosi_in = pin_sync[`GPX_PIN_MOSI];
  assign sei_miso_in = pin_sync[`GPX_PIN_MISO];
  assign sei_sclk_in = pin_sync[`GPX_PIN_SCLK];

  // function bit zero is the mode-fault control, not a pin mux bit
  assign sei_mode_fault_disable = r_q.fn[`GPX_PIN_SS];
  assign sei_sclk_master        = (mode[`GPX_PIN_SCLK] == gpx_pkg::GPX_PIN_FUNC);

  always_comb begin
    func_out                 = '0;
    func_out[`GPX_PIN_MOSI]  = sei_mosi_out;
    func_out[`GPX_PIN_MISO]  = sei_miso_out;
    func_out[`GPX_PIN_SCLK]  = sei_sclk_out;
    od_en                    = {r_q.open_drain_enable, 1'b0};
  end

  generate
    for (genvar i = 0; i < NP; i++) begin : g_pin
      logic fn_bit;
      // pin zero's function bit never selects a serial output
      assign fn_bit  = (i == `GPX_PIN_SS) ? 1'b0 : r_q.fn[i];
      assign mode[i] = gpx_pkg::gpx_pin_mode(r_q.dir[i], fn_bit);
      assign drv_map[i] = (mode[i] == gpx_pkg::GPX_PIN_OUT) ||
                          (mode[i] == gpx_pkg::GPX_PIN_FUNC);
      assign fn_map[i]  = (mode[i] == gpx_pkg::GPX_PIN_FUNC);
      // output bits read back the latch, input bits the pin
      assign data_view[i] = r_q.dir[i] ? r_q.latch[i] : pin_sync[i];

      gpx_pin_cell u_cell (
        .pclk     (pclk),
        .presetn  (presetn),
        .mode     (mode[i]),
        .latch    (r_q.latch[i]),
        .func_out (func_out[i]),
        .od_en    (od_en[i]),
        .pin_o    (pin_o[i]),
        .pin_oe   (pin_oe[i])
      );
    end
  endgenerate

  // any of pins one to three left with function set and direction clear
  assign bad_cfg = |(r_q.fn[NP-1:1] & ~r_q.dir[NP-1:1]);

  assign setup  = psel & ~penable;
  assign access = psel & penable;

  always_comb begin
    r_d = r_q;
    // read data and error are captured in the setup cycle
    if (setup) begin
      r_d.rdata  = 32'h0000_0000;
      r_d.slverr = ~gpx_mapped(paddr) | (pwrite & gpx_hit(paddr, `GPX_IDX_STAT));
      if (!pwrite) begin
        if (gpx_hit(paddr, `GPX_IDX_DATA)) begin
          r_d.rdata[NP-1:0] = data_view;
        end
        if (gpx_hit(paddr, `GPX_IDX_ODE)) begin
          r_d.rdata[`GPX_ODE_W-1:0] = r_q.open_drain_enable;
        end
        if (gpx_hit(paddr, `GPX_IDX_STAT)) begin
          r_d.rdata[`GPX_STAT_LVL_LSB +: NP] = pin_sync;
          r_d.rdata[`GPX_STAT_DRV_LSB +: NP] = drv_map;
          r_d.rdata[`GPX_STAT_FN_LSB +: NP]  = fn_map;
          r_d.rdata[`GPX_STAT_MFD_BIT]       = r_q.fn[`GPX_PIN_SS];
          r_d.rdata[`GPX_STAT_BAD_BIT]       = bad_cfg;
        end
        // direction and function are write-only and read as zero
      end
    end
    // writes land at the access edge; only byte lane 0 carries data
    if (access && pwrite && !r_q.slverr && pstrb[0]) begin
      if (gpx_hit(paddr, `GPX_IDX_DATA)) begin
        r_d.latch = pwdata[NP-1:0];
      end
      if (gpx_hit(paddr, `GPX_IDX_DIR)) begin
        r_d.dir = pwdata[NP-1:0];
      end
      if (gpx_hit(paddr, `GPX_IDX_FUNC)) begin
        r_d.fn = pwdata[NP-1:0];
      end
      if (gpx_hit(paddr, `GPX_IDX_ODE)) begin
        r_d.open_drain_enable = pwdata[`GPX_ODE_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q        <= '0;
      r_q.latch  <= `GPX_RST_LATCH;
      r_q.dir    <= `GPX_RST_DIR;
      r_q.fn     <= `GPX_RST_FUNC;
      r_q.open_drain_enable    <= `GPX_RST_ODE;
    end else begin
      r_q <= r_d;
    end
  end

  // zero wait states: the access cycle always completes
  assign pready  = access;
  assign pslverr = access & r_q.slverr;
  assign prdata  = r_q.rdata;
endmodule : gpx_port

// >>> gpx_port_asserts.sv
// Purpose: concurrent checks on the port pins and serial pin routing
// Assumes: bound to gpx_port, single pclk domain
// Notes:   up_q hides the synchroniser's reset fill from the depth-2 sclk and miso forwarding checks
`timescale 1ns/1ps
module gpx_port_chk (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [3:0] pin_i,
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe,
  input wire logic       sei_ss_n,
  input wire logic       sei_mosi_in,
  input wire logic       sei_miso_in,
  input wire logic       sei_sclk_in,
  input wire logic       sei_sclk_out,
  input wire logic       sei_mode_fault_disable,
  input wire logic       sei_sclk_master
);
  logic [1:0] up_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_q <= 2'h0;
    else if (!up_q[1]) up_q <= up_q + 2'h1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_sclk_in; up_q[1] |-> sei_sclk_in == $past(pin_i[3], 2); endproperty
  a_sclk_in: assert property (p_sclk_in) else $error("sclk input not forwarded");
  property p_miso_in; up_q[1] |-> sei_miso_in == $past(pin_i[2], 2); endproperty
  a_miso_in: assert property (p_miso_in) else $error("miso input not forwarded");
  property p_ss; $fell(pin_i[0]) |-> ##2 !sei_ss_n; endproperty
  a_ss: assert property (p_ss) else $error("slave select not low after pin fell");
  property p_mosi; $rose(pin_i[1]) |-> ##2 sei_mosi_in; endproperty
  a_mosi: assert property (p_mosi) else $error("mosi input not high after pin rose");
  // open drain leaves the pin released for a one, so both drive kinds fit this form
  property p_sclk_drv;
    sei_sclk_master && $past(sei_sclk_master) |->
      (pin_oe[3] ? pin_o[3] : 1'b1) == $past(sei_sclk_out);
  endproperty
  a_sclk_drv: assert property (p_sclk_drv) else $error("pin three not driving sclk");
  property p_rst;
    $rose(presetn) |-> pin_oe == 4'h0 && !sei_sclk_master && !sei_mode_fault_disable;
  endproperty
  a_rst: assert property (p_rst) else $error("pins not inputs after reset");
  property p_dir0; $changed(pin_oe[0]) |-> $past(psel && penable && pwrite, 2); endproperty
  a_dir0: assert property (p_dir0) else $error("pin zero enable moved without write");
  property p_mfd; $changed(sei_mode_fault_disable) |-> $past(psel && penable && pwrite); endproperty
  a_mfd: assert property (p_mfd) else $error("mode fault bit moved without write");
endmodule : gpx_port_chk

bind gpx_port gpx_port_chk gpx_port_chk_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .pin_i, .pin_o, .pin_oe, .sei_ss_n,
  .sei_mosi_in, .sei_miso_in, .sei_sclk_in, .sei_sclk_out, .sei_mode_fault_disable,
  .sei_sclk_master);

// >>> gpx_pin_dev.sv
// Purpose: pins plus the external serial device sitting on them
// Assumes: bench never drives a pin the port drives
// Notes:   no pull-ups, so a free pin toggles every cycle rather than hold a value
`timescale 1ns/1ps
module gpx_pin_dev (
  input wire logic       pclk,
  input wire logic [3:0] pin_o,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] ext_v,
  input wire logic [3:0] ext_en,
  output logic     [3:0] pin_i
);
  logic [3:0] flt_q = 4'h5;
  always @(posedge pclk) flt_q <= ~flt_q;
  // external device drives only pins the port leaves as inputs
  always_comb pin_i = (pin_oe & pin_o) | (~pin_oe & ((ext_en & ext_v) | (~ext_en & flt_q)));
endmodule : gpx_pin_dev

// >>> tb_top.sv
// Purpose: self-checking bench for gpx_port
// Assumes: APB answer taken whenever pready is high
// Notes:   expected bus results are queued; the monitor pops one per access
`timescale 1ns/1ps
`include "gpx_defines.svh"
module tb_top;
  localparam logic [11:0] A_DAT = {2'b0, `GPX_IDX_DATA, 2'b00};
  localparam logic [11:0] A_DIR = {2'b0, `GPX_IDX_DIR, 2'b00};
  localparam logic [11:0] A_FN  = {2'b0, `GPX_IDX_FUNC, 2'b00};
  localparam logic [11:0] A_OD  = {2'b0, `GPX_IDX_ODE, 2'b00};
  localparam logic [11:0] A_ST  = {2'b0, `GPX_IDX_STAT, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        sei_ss_n, sei_mosi_in, sei_miso_in, sei_sclk_in, sei_mode_fault_disable;
  logic        sei_mosi_out, sei_miso_out, sei_sclk_out, sei_sclk_master;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [3:0]  pstrb, pin_i, pin_o, pin_oe, ext_v, ext_en;
  logic [33:0] exp_q[$];
  logic [33:0] ent;
  int          n_mismatch, total_checks, cyc;

  gpx_port gpx_port_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .pin_i, .pin_o, .pin_oe, .sei_ss_n, .sei_mosi_in,
    .sei_miso_in, .sei_sclk_in, .sei_mosi_out, .sei_miso_out, .sei_sclk_out,
    .sei_mode_fault_disable, .sei_sclk_master);
  gpx_pin_dev gpx_pin_dev_inst (.pclk, .pin_o, .pin_oe, .ext_v, .ext_en, .pin_i);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  // e is the expected pslverr, x the expected read data
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic e, input logic [31:0] x);
    exp_q.push_back({!w, e, x});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  always @(posedge pclk) begin
    cyc++;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && exp_q.size() > 0) begin
      ent = exp_q.pop_front();
      cmp("pslverr", {31'h0, ent[32]}, {31'h0, pslverr});
      if (ent[33]) cmp("prdata", ent[31:0], prdata);
    end
    // the verdict ends the run, so the ceiling is the last thing this process does
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sei_mosi_out, sei_miso_out, sei_sclk_out} = 3'h0;
    pstrb = 4'hF;
    ext_v = 4'h5;
    ext_en = 4'hF;
    seed = 32'd35;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    cmp("pin_oe", 32'h0, pin_oe);
    xfer(0, A_DIR, 0, 0, 0);
    xfer(0, A_DAT, 0, 0, 32'h5);
    xfer(1, A_DIR, 32'hF, 0, 0);
    xfer(0, A_DAT, 0, 0, 32'hF);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      ext_en <= ~seed[11:8];
      ext_v <= seed[3:0];
      xfer(1, A_DAT, seed[7:4], 0, 0);
      xfer(1, A_DIR, seed[11:8], 0, 0);
      repeat (3) @(posedge pclk);
      cmp("pin_oe", seed[11:8], pin_oe);
      cmp("pin_o", seed[11:8] & seed[7:4], pin_o & pin_oe);
      xfer(0, A_DAT, 0, 0, (seed[11:8] & seed[7:4]) | (~seed[11:8] & seed[3:0]));
    end
    $display("test port done");
    ext_en <= 4'h3;
    ext_v <= 4'h2;
    // direction first, so pins two and three never see function without direction
    xfer(1, A_DIR, 32'hC, 0, 0);
    xfer(1, A_FN, 32'hF, 0, 0);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      sei_miso_out <= seed[0];
      sei_sclk_out <= seed[1];
      repeat (4) @(posedge pclk);
      cmp("miso pin", {seed[0], 1'b1}, {pin_o[2], pin_oe[2]});
      cmp("pin_oe", 32'hC, pin_oe);
      cmp("serial in", {seed[1:0], 2'b10}, {sei_sclk_in, sei_miso_in, sei_mosi_in, sei_ss_n});
      cmp("mfd", 32'h1, sei_mode_fault_disable);
      cmp("sclk master", 32'h1, sei_sclk_master);
    end
    xfer(0, A_ST, 0, 0, {18'h0, 2'b11, 8'hCC, seed[1:0], 2'b10});
    $display("test serial done");
    xfer(1, A_OD, 32'h4, 0, 0);
    for (int i = 0; i < 2; i++) begin
      sei_sclk_out <= i[0];
      repeat (3) @(posedge pclk);
      cmp("od sclk", {1'b0, ~i[0]}, {pin_o[3], pin_oe[3]});
    end
    xfer(0, A_OD, 0, 0, 32'h4);
    // a write without byte lane 0 must leave the register alone
    pstrb <= 4'hE;
    xfer(1, A_OD, 32'h0, 0, 0);
    pstrb <= 4'hF;
    xfer(0, A_OD, 0, 0, 32'h4);
    xfer(1, 12'h060, 1, 1, 0);
    xfer(1, 12'h049, 1, 1, 0);
    xfer(1, A_ST, 1, 1, 0);
    xfer(0, 12'h060, 0, 1, 0);
    $display("test open drain and refusals done");
    ext_en <= 4'hF;
    ext_v <= 4'hA;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    cmp("mfd", 32'h0, sei_mode_fault_disable);
    repeat (3) @(posedge pclk);
    xfer(0, A_DAT, 0, 0, 32'hA);
    xfer(1, A_DIR, 32'hF, 0, 0);
    xfer(0, A_DAT, 0, 0, 32'hF);
    $display("test second reset done");
    give_verdict();
  end
endmodule : tb_top
